// >>> design/wdg_consts.svh
// register map, field positions, reset values and timing counts of the watchdog
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH
`define WDG_CTRL_OFS 4'h0
`define WDG_OPT_OFS 4'h4
`define WDG_CMD_OFS 4'h8
`define WDG_STAT_OFS 4'hC
`define WDG_CTRL_RST 8'h08
`define WDG_OPT_RST 8'hFF
`define WDG_SOFT_EN_BIT 0
`define WDG_PS_LSB 1
`define WDG_PS_MSB 4
`define WDG_OWNER_BIT 3
`define WDG_RATIO_MSB 2
`define WDG_CMD_CLR_BIT 0
`define WDG_CMD_SLEEP_BIT 1
`define WDG_CLK_HZ 40000000
`define WDG_LFOSC_HZ 31000
`define WDG_LF_DIV ((`WDG_CLK_HZ) / (`WDG_LFOSC_HZ))
`define WDG_OST_PERIODS 1024
`define WDG_PS_BASE 16'h0020
`define WDG_PS_MAX 4'hB
`endif

// >>> design/wdg_pkg.sv
// types shared by the watchdog and sleep logic
package wdg_pkg;
   typedef enum logic [2:0] {
      WDG_LOW_POWER_CRYSTAL = 3'h0,
      WDG_STD_CRYSTAL_MODE = 3'h1,
      WDG_FAST_CRYSTAL_MODE = 3'h2,
      WDG_EXTERNAL_CLOCK_MODE = 3'h3,
      WDG_INTERNAL_OSC_MODE = 3'h4,
      WDG_EXTERNAL_RC_MODE = 3'h5,
      WDG_TIMER1_OSC_MODE = 3'h6
   } wdg_osc_mode_t;
   typedef enum logic [1:0] {
      WDG_AWAKE,
      WDG_ASLEEP,
      WDG_OST
   } wdg_state_t;
endpackage

// >>> design/wdg_watchdog_sleep.sv
// watchdog timer with sleep entry, wake-up and reset-cause flags
// Overview of operation
// - watchdog counts ticks of slow internal oscillator
// - 16-bit prescaler ratio set by period select
// - shared 8-bit prescaler serves watchdog when assigned
// - control register resets to 0x08 every reset
// - start-up timer holds watchdog in reset
// - fuse set runs watchdog, ignores soft enable
// - fuse clear, soft enable bit gates watchdog
// - period codes 1:32 doubling to 1:65536
// - soft enable bit 0, bits 7-5 zero
// - clear on disable, clear, osc fail, wake
// - crystal wake holds watchdog clear through start-up
// - start-up 1024 osc periods, crystal modes only
// - sleep clears watchdog and power-down flag, sets expiry flag, stops oscillator
// - leave sleep on pin reset, watchdog, interrupt
// - watchdog wake clears expiry flag
// - never drive the external reset pin low
// - enabled interrupt wakes; global enable picks vector
// - sleep prefetches next instruction
// - pending interrupt makes sleep a no-operation
// - interrupt during sleep wakes with full sleep effects
// - every wake-up clears the watchdog
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"
module wdg_watchdog_sleep
   import wdg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic watchdog_fuse_enable,
   input wire wdg_osc_mode_t osc_mode,
   input wire logic sys_osc_tick,
   input wire logic osc_fail,
   input wire logic [7:0] irq_flags,
   input wire logic [7:0] irq_enables,
   input wire logic global_irq_enable,
   input wire logic external_reset_pin_b_in,
   output logic external_reset_pin_b_out,
   output logic external_reset_pin_oe_b,
   output logic device_reset,
   output logic wake_continue,
   output logic wake_vector,
   output logic prefetch_next,
   output logic osc_driver_off,
   output logic io_hold
);

   localparam logic [10:0] LF_LAST = 11'(`WDG_LF_DIV - 1);
   localparam logic [9:0] OST_LAST = 10'(`WDG_OST_PERIODS - 1);

   function automatic logic [15:0] presc_last(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `WDG_PS_MAX) ? `WDG_PS_MAX : code;
      presc_last = (`WDG_PS_BASE << c) - 16'h0001;
   endfunction

   function automatic logic is_crystal(input wdg_osc_mode_t m);
      is_crystal = (m == WDG_LOW_POWER_CRYSTAL) || (m == WDG_STD_CRYSTAL_MODE) ||
                   (m == WDG_FAST_CRYSTAL_MODE);
   endfunction

   logic ack;
   logic [7:0] watchdog_control;
   logic [7:0] option_prescale_control;
   logic powerdown_flag;
   logic expiry_flag;
   wdg_state_t state;
   logic [10:0] lf_cnt;
   logic [15:0] presc;
   logic [7:0] post;
   logic [9:0] ost_cnt;

   logic wr_go;
   logic cmd_we;
   logic clr_instr;
   logic sleep_instr;
   logic lf_tick;
   logic wdt_en;
   logic pend;
   logic ext_rst;
   logic sleep_go;
   logic sleep_nop;
   logic wake_go;
   logic wdt_clear;
   logic base_clear;
   logic presc_done;
   logic wdt_ovf;
   logic dev_rst_now;
   logic [3:0] ps_code;
   logic [7:0] post_last;
   logic [7:0] status_word;

   // bus slave: one wait cycle, then the answer
   assign waitrequest = (read || write) && !ack;
   assign wr_go = write && ack;
   assign cmd_we = wr_go && (address == `WDG_CMD_OFS);
   assign clr_instr = cmd_we && writedata[`WDG_CMD_CLR_BIT];
   assign sleep_instr = cmd_we && writedata[`WDG_CMD_SLEEP_BIT];

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ack <= 1'b0;
      end else begin
         ack <= (read || write) && !ack;
      end
   end

   assign status_word = {3'h0, state == WDG_OST, state == WDG_ASLEEP, wdt_en,
                         expiry_flag, powerdown_flag};

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         readdata <= 32'h0000_0000;
      end else if (read && !ack) begin
         case (address)
            `WDG_CTRL_OFS: readdata <= {24'h0, 3'h0, watchdog_control[4:0]};
            `WDG_OPT_OFS: readdata <= {24'h0, option_prescale_control};
            `WDG_STAT_OFS: readdata <= {24'h0, status_word};
            default: readdata <= 32'h0000_0000;
         endcase
      end
   end

   // control registers come back to their reset values on every device reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         watchdog_control <= `WDG_CTRL_RST;
      end else if (dev_rst_now) begin
         watchdog_control <= `WDG_CTRL_RST;
      end else if (wr_go && address == `WDG_CTRL_OFS) begin
         watchdog_control <= {3'h0, writedata[4:0]};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         option_prescale_control <= `WDG_OPT_RST;
      end else if (dev_rst_now) begin
         option_prescale_control <= `WDG_OPT_RST;
      end else if (wr_go && address == `WDG_OPT_OFS) begin
         option_prescale_control <= writedata[7:0];
      end
   end

   assign ps_code = watchdog_control[`WDG_PS_MSB:`WDG_PS_LSB];
   assign post_last = (8'h01 << option_prescale_control[`WDG_RATIO_MSB:0]) - 8'h01;
   assign wdt_en = watchdog_fuse_enable || watchdog_control[`WDG_SOFT_EN_BIT];
   assign pend = |(irq_flags & irq_enables);
   assign ext_rst = !external_reset_pin_b_in;

   // the device has no pull-down on its own reset pin
   assign external_reset_pin_b_out = 1'b0;
   assign external_reset_pin_oe_b = 1'b1;

   assign sleep_nop = (state == WDG_AWAKE) && sleep_instr && pend;
   assign sleep_go = (state == WDG_AWAKE) && sleep_instr && !pend && !ext_rst;
   assign wake_go = (state == WDG_ASLEEP) && !ext_rst && (pend || wdt_ovf);
   assign dev_rst_now = ext_rst || (wdt_ovf && state == WDG_AWAKE);

   // restart causes that do not hang on the count itself, so overflow cannot feed back into its own gate
   assign base_clear = ext_rst || !wdt_en || clr_instr || osc_fail ||
                       sleep_go || (state == WDG_ASLEEP && pend) ||
                       (state == WDG_OST);
   // every event that restarts the count, prescalers included
   assign wdt_clear = base_clear || dev_rst_now || wake_go;

   // slow oscillator time base, derived from the main clock
   assign lf_tick = (lf_cnt == LF_LAST);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         lf_cnt <= 11'h000;
      end else if (lf_tick) begin
         lf_cnt <= 11'h000;
      end else begin
         lf_cnt <= lf_cnt + 11'h001;
      end
   end

   assign presc_done = lf_tick && !base_clear && (presc == presc_last(ps_code));

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         presc <= 16'h0000;
      end else if (wdt_clear) begin
         presc <= 16'h0000;
      end else if (lf_tick) begin
         if (presc == presc_last(ps_code)) begin
            presc <= 16'h0000;
         end else begin
            presc <= presc + 16'h0001;
         end
      end
   end

   // shared prescaler only stretches the period while assigned to the watchdog
   assign wdt_ovf = presc_done &&
                    (!option_prescale_control[`WDG_OWNER_BIT] || post == post_last);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         post <= 8'h00;
      end else if (wdt_clear || !option_prescale_control[`WDG_OWNER_BIT]) begin
         post <= 8'h00;
      end else if (presc_done) begin
         if (post == post_last) begin
            post <= 8'h00;
         end else begin
            post <= post + 8'h01;
         end
      end
   end

   // sleep, wake and start-up sequencing
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= WDG_AWAKE;
      end else begin
         case (state)
            WDG_AWAKE: begin
               if (sleep_go) begin
                  state <= WDG_ASLEEP;
               end
            end
            WDG_ASLEEP: begin
               if (ext_rst) begin
                  state <= WDG_AWAKE;
               end else if (wake_go) begin
                  state <= is_crystal(osc_mode) ? WDG_OST : WDG_AWAKE;
               end
            end
            WDG_OST: begin
               if (ext_rst || (sys_osc_tick && ost_cnt == OST_LAST)) begin
                  state <= WDG_AWAKE;
               end
            end
            default: state <= WDG_AWAKE;
         endcase
      end
   end

   // start-up count in oscillator periods; a tick is one period
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ost_cnt <= 10'h000;
      end else if (state != WDG_OST) begin
         ost_cnt <= 10'h000;
      end else if (sys_osc_tick) begin
         ost_cnt <= ost_cnt + 10'h001;
      end
   end

   // power-down flag: set at power-up, cleared by sleep entry
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         powerdown_flag <= 1'b1;
      end else if (sleep_go) begin
         powerdown_flag <= 1'b0;
      end else if (clr_instr) begin
         powerdown_flag <= 1'b1;
      end
   end

   // expiry flag low means the watchdog ran out
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         expiry_flag <= 1'b1;
      end else if (wdt_ovf) begin
         expiry_flag <= 1'b0;
      end else if (sleep_go || clr_instr) begin
         expiry_flag <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         device_reset <= 1'b0;
         wake_continue <= 1'b0;
         wake_vector <= 1'b0;
         prefetch_next <= 1'b0;
      end else begin
         device_reset <= dev_rst_now;
         wake_continue <= wake_go;
         wake_vector <= wake_go && pend && global_irq_enable;
         prefetch_next <= sleep_go || sleep_nop;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         osc_driver_off <= 1'b0;
         io_hold <= 1'b0;
      end else begin
         osc_driver_off <= sleep_go || (state == WDG_ASLEEP && !wake_go && !ext_rst);
         io_hold <= sleep_go || (state == WDG_ASLEEP && !wake_go && !ext_rst);
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence s_enter_sleep;
      state == WDG_AWAKE && sleep_instr && !pend && !ext_rst;
   endsequence

   sequence s_asleep_cleared;
      state == WDG_ASLEEP && !powerdown_flag && expiry_flag && presc == 16'h0000;
   endsequence

   property p_ctrl_reset;
      dev_rst_now |=> watchdog_control == `WDG_CTRL_RST;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reloaded");

   property p_fuse_runs;
      watchdog_fuse_enable && !watchdog_control[0] && lf_tick && !wdt_clear &&
      presc != presc_last(ps_code) |=> presc == $past(presc) + 16'h0001;
   endproperty
   a_fuse_runs: assert property (p_fuse_runs) else $error("fuse did not run watchdog");

   property p_soft_off;
      !watchdog_fuse_enable && !watchdog_control[0] |=> presc == 16'h0000 && post == 8'h00;
   endproperty
   a_soft_off: assert property (p_soft_off) else $error("disabled watchdog counted");

   property p_ost_hold;
      state == WDG_OST |=> presc == 16'h0000;
   endproperty
   a_ost_hold: assert property (p_ost_hold) else $error("watchdog ran during start-up");

   property p_sleep_entry;
      s_enter_sleep |=> s_asleep_cleared ##0 (io_hold && osc_driver_off);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry effects missing");

   property p_sleep_nop;
      state == WDG_AWAKE && sleep_instr && pend && !dev_rst_now |=>
         state == WDG_AWAKE && $stable(powerdown_flag);
   endproperty
   a_sleep_nop: assert property (p_sleep_nop) else $error("sleep not a no-operation");

   property p_irq_wake;
      state == WDG_ASLEEP && pend && !ext_rst |=> state != WDG_ASLEEP && presc == 16'h0000 &&
         wake_continue;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("interrupt did not wake");

   property p_wdt_reset;
      wdt_ovf && state == WDG_AWAKE |=> device_reset && !expiry_flag;
   endproperty
   a_wdt_reset: assert property (p_wdt_reset) else $error("overflow did not reset");

   property p_wdt_wake;
      wdt_ovf && state == WDG_ASLEEP && !ext_rst |=> !device_reset && !expiry_flag && wake_continue;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("overflow did not wake");

   property p_pin_free;
      external_reset_pin_oe_b;
   endproperty
   a_pin_free: assert property (p_pin_free) else $error("reset pin driven");

endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the watchdog, sleep and wake-up block
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"
module tb_top;
   import wdg_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic fuse = 1'b0;
   wdg_osc_mode_t osc_mode = WDG_INTERNAL_OSC_MODE;
   logic sys_osc_tick = 1'b0;
   logic [7:0] irq_flags = 8'h00;
   logic [7:0] irq_enables = 8'h00;
   logic gen = 1'b0;
   logic osc_fail = 1'b0;
   logic pin_b = 1'b1;
   logic pin_out, pin_oe_b, device_reset, wake_continue, wake_vector, prefetch_next, osc_driver_off, io_hold;
   int mismatches = 0;
   int samples_checked = 0;
   int n_rst = 0, n_wake = 0, n_vec = 0, n_pref = 0, n_drive = 0;
   logic [31:0] rd;

   wdg_watchdog_sleep wdg_watchdog_sleep_i (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .watchdog_fuse_enable(fuse), .osc_mode(osc_mode), .sys_osc_tick(sys_osc_tick), .osc_fail(osc_fail),
      .irq_flags(irq_flags), .irq_enables(irq_enables), .global_irq_enable(gen),
      .external_reset_pin_b_in(pin_b), .external_reset_pin_b_out(pin_out),
      .external_reset_pin_oe_b(pin_oe_b), .device_reset(device_reset), .wake_continue(wake_continue),
      .wake_vector(wake_vector), .prefetch_next(prefetch_next), .osc_driver_off(osc_driver_off),
      .io_hold(io_hold));

   initial forever #12.5 clock = ~clock;

   // a system oscillator period lasts two clocks, so start-up spans 2048 clocks
   always @(posedge clock) sys_osc_tick <= ~sys_osc_tick;

   // pulses are counted from pre-edge values, so no race with the design's updates
   always @(posedge clock) begin
      if (device_reset === 1'b1) n_rst++;
      if (wake_continue === 1'b1) n_wake++;
      if (wake_vector === 1'b1) n_vec++;
      if (prefetch_next === 1'b1) n_pref++;
      if (pin_oe_b !== 1'b1) n_drive++;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // request held until the edge at which waitrequest is low; that edge takes the data
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
      int i;
      @(posedge clock);
      address <= a;
      writedata <= {24'h0, d};
      read <= !wr;
      write <= wr;
      for (i = 0; i < 100; i++) begin
         @(posedge clock);
         if (waitrequest === 1'b0) break;
      end
      if (i == 100) check("waitrequest", 32'h1, 32'h0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d, rd);
   endtask

   task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
      bus(1'b0, a, 8'h00, rd);
      check(name, rd & m, exp);
   endtask

   task automatic t_regs;
      rdchk("control reset", `WDG_CTRL_OFS, `WDG_CTRL_RST, 32'hFFFFFFFF);
      rdchk("option reset", `WDG_OPT_OFS, `WDG_OPT_RST, 32'hFFFFFFFF);
      rdchk("status reset", `WDG_STAT_OFS, 32'h03, 32'h07);
      wr(`WDG_CTRL_OFS, 8'hFF);
      rdchk("control upper bits", `WDG_CTRL_OFS, 32'h1F, 32'hFFFFFFFF);
      rdchk("soft on", `WDG_STAT_OFS, 32'h04, 32'h04);
      wr(`WDG_CTRL_OFS, 8'h08);
      rdchk("soft off", `WDG_STAT_OFS, 32'h00, 32'h04);
      @(posedge clock);
      fuse <= 1'b1;
      rdchk("fuse on", `WDG_STAT_OFS, 32'h04, 32'h04);
      // long enough for a slow tick to reach the counter with the fuse alone
      repeat (1300) @(posedge clock);
      fuse <= 1'b0;
      rdchk("unmapped", 4'h2, 32'h0, 32'hFFFFFFFF);
      rdchk("command reads zero", `WDG_CMD_OFS, 32'h0, 32'hFFFFFFFF);
   endtask

   task automatic t_noop;
      int p;
      @(posedge clock);
      irq_enables <= 8'h01;
      irq_flags <= 8'h01;
      p = n_pref;
      wr(`WDG_CMD_OFS, 8'h02);
      repeat (2) @(posedge clock);
      check("noop prefetch", n_pref - p, 1);
      rdchk("noop status", `WDG_STAT_OFS, 32'h03, 32'h0B);
      @(posedge clock);
      irq_flags <= 8'h00;
   endtask

   task automatic t_sleep(input logic g, input wdg_osc_mode_t m);
      int w, v, p, i;
      @(posedge clock);
      gen <= g;
      osc_mode <= m;
      irq_enables <= 8'h01;
      wr(`WDG_CMD_OFS, 8'h01);
      p = n_pref;
      w = n_wake;
      v = n_vec;
      wr(`WDG_CMD_OFS, 8'h02);
      rdchk("asleep status", `WDG_STAT_OFS, 32'h0A, 32'h1B);
      check("io hold", io_hold, 1'b1);
      check("osc driver off", osc_driver_off, 1'b1);
      check("sleep prefetch", n_pref - p, 1);
      @(posedge clock);
      irq_flags <= 8'h01;
      for (i = 0; i < 50 && n_wake == w; i++) @(posedge clock);
      check("wake pulse", n_wake - w, 1);
      check("vector pulse", n_vec - v, g);
      @(posedge clock);
      irq_flags <= 8'h00;
      if (m == WDG_STD_CRYSTAL_MODE) begin
         repeat (1700) @(posedge clock);
         rdchk("startup running", `WDG_STAT_OFS, 32'h10, 32'h18);
         repeat (600) @(posedge clock);
      end
      rdchk("awake again", `WDG_STAT_OFS, 32'h00, 32'h18);
      check("io released", io_hold, 1'b0);
   endtask

   task automatic t_wdt_wake;
      int w, r, i, nom;
      nom = (`WDG_PS_BASE) * (`WDG_LF_DIV);
      osc_mode <= WDG_EXTERNAL_RC_MODE;
      wr(`WDG_OPT_OFS, 8'h00);
      wr(`WDG_CTRL_OFS, 8'h01);
      w = n_wake;
      r = n_rst;
      wr(`WDG_CMD_OFS, 8'h02);
      // a held oscillator failure keeps the count at zero, so timing starts at its release
      osc_fail <= 1'b1;
      repeat (3000) @(posedge clock);
      osc_fail <= 1'b0;
      for (i = 0; i < 45000 && n_wake == w; i++) @(posedge clock);
      check("wake time", (i > nom - (`WDG_LF_DIV) - 10) && (i < nom + (`WDG_LF_DIV) + 10), 1'b1);
      check("no reset on wake", n_rst - r, 0);
      rdchk("expiry after wake", `WDG_STAT_OFS, 32'h00, 32'h1A);
   endtask

   task automatic t_overflow;
      int r, i, nom;
      nom = (`WDG_PS_BASE) * (`WDG_LF_DIV);
      wr(`WDG_OPT_OFS, 8'h00);
      wr(`WDG_CTRL_OFS, 8'h01);
      r = n_rst;
      wr(`WDG_CMD_OFS, 8'h01);
      for (i = 0; i < 45000 && n_rst == r; i++) @(posedge clock);
      check("overflow time", (i > nom - (`WDG_LF_DIV) - 10) && (i < nom + (`WDG_LF_DIV) + 10), 1'b1);
      rdchk("expiry after overflow", `WDG_STAT_OFS, 32'h00, 32'h02);
      rdchk("control reloaded", `WDG_CTRL_OFS, `WDG_CTRL_RST, 32'hFFFFFFFF);
      @(posedge clock);
      pin_b <= 1'b0;
      @(posedge clock);
      pin_b <= 1'b1;
      repeat (3) @(posedge clock);
      check("pin reset", n_rst - r, 2);
      check("pin never driven", n_drive, 0);
      check("pin out level", pin_out, 1'b0);
   endtask

   task automatic summarize;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(95000 * 25);
      mismatches++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      t_regs();
      t_noop();
      t_sleep(1'b0, WDG_INTERNAL_OSC_MODE);
      t_sleep(1'b1, WDG_STD_CRYSTAL_MODE);
      t_wdt_wake();
      t_overflow();
      summarize();
   end
endmodule
`default_nettype wire
